// ===== gpio_exp_i2c.sv
// I2C slave front end of a 16-bit port expander with command pointer
// Overview of operation
// - After reset all sixteen port pins are undriven inputs.
// - Slave address low bits come from three strap inputs; eight addresses.
// - Address byte last bit: 1 means read, 0 means write.
// - First byte after acknowledged write address is stored in the command pointer.
// - Pointer low three bits select input, output, polarity or configuration.
// - Pointer bit 6 with low four bits selects extended registers.
// - Pointer is loaded only by writes, its bit 0 toggles after each acked data byte of a read or write; never read back.
// - Low pins map to bank 0 bits, high pins to bank 1 bits.
// - Codes 00h-07h basic, 40h-4Fh extended as per register map.
// - Input registers show pin levels XOR polarity regardless of direction; writes ignored.
// - Output registers read back the written value, not the pins.
`timescale 1ns/1ps
module gpio_exp_i2c
    import gpio_exp_pkg::*;
#(
    parameter int BANKS = 2
) (
    input  wire logic                            clk_sys,
    input  wire logic                            reset_n,
    input  wire logic                            scl_in,
    input  wire logic                            sda_in,
    output logic                                 sda_out,
    output logic                                 sda_oe,
    input  wire logic                            addr_strap_0,
    input  wire logic                            addr_strap_1,
    input  wire logic                            addr_strap_2,
    input  wire logic [gpio_exp_pkg::BANK_W-1:0] low_bank_pins_in,
    output logic      [gpio_exp_pkg::BANK_W-1:0] low_bank_pins_out,
    output logic      [gpio_exp_pkg::BANK_W-1:0] low_bank_pins_oe,
    input  wire logic [gpio_exp_pkg::BANK_W-1:0] high_bank_pins_in,
    output logic      [gpio_exp_pkg::BANK_W-1:0] high_bank_pins_out,
    output logic      [gpio_exp_pkg::BANK_W-1:0] high_bank_pins_oe
);
    import gpio_exp_pkg::*;

    if (BANKS != 2) begin : g_bank_check
        $error("Only two banks are supported");
    end

    typedef struct packed {
        i2c_e                    st;
        logic [3:0]              cnt;
        logic [7:0]              shift;
        logic [7:0]              cmd;
        logic                    scl_d;
        logic                    sda_d;
        logic [1:0][7:0]         outp;
        logic [1:0][7:0]         pol;
        logic [1:0][7:0]         cfg;
        logic [EXT_N-1:0][7:0]   ext;
        logic [1:0][7:0]         oe;
        logic                    sda_oe;
        logic                    sda_zero;
    } state_s;

    localparam state_s STATE_RESET = '{
        st: ST_IDLE, cnt: CNT_ZERO, shift: CMD_RESET, cmd: CMD_RESET,
        scl_d: 1'b1, sda_d: 1'b1, outp: {OUT_RESET, OUT_RESET},
        pol: {POL_RESET, POL_RESET}, cfg: {CFG_RESET, CFG_RESET},
        ext: EXT_RESET, oe: '0, sda_oe: 1'b0, sda_zero: 1'b0};

    logic [1:0]          rst_sync;
    logic                rst_n;
    logic [1:0]          scl_sync;
    logic [1:0]          sda_sync;
    logic [1:0][15:0]    pin_sync;
    logic [2:0]          strap_meta;
    logic [2:0]          strap;
    state_s              cur;
    state_s              next;
    logic [1:0][7:0]     pins;
    logic                scl_rise;
    logic                scl_fall;
    logic                start_cond;
    logic                stop_cond;
    logic [7:0]          rd_data;
    logic [6:0]          my_addr;

    // Reset released through two flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Two-flop synchronisers for bus, straps and port pins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            pin_sync <= '0;
            strap_meta <= 3'h0;
            strap    <= 3'h0;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            pin_sync <= {pin_sync[0], high_bank_pins_in, low_bank_pins_in};
            strap_meta <= {addr_strap_2, addr_strap_1, addr_strap_0};
            strap    <= strap_meta;
        end
    end

    // Pins one to one onto bank bits
    assign pins       = pin_sync[1];
    assign my_addr    = {ADDR_FIXED, strap};
    assign scl_rise   = scl_sync[1] & ~cur.scl_d;
    assign scl_fall   = ~scl_sync[1] & cur.scl_d;
    assign start_cond = scl_sync[1] & cur.scl_d & cur.sda_d & ~sda_sync[1];
    assign stop_cond  = scl_sync[1] & cur.scl_d & ~cur.sda_d & sda_sync[1];

    // Read mux; status and the gap code read as zero since no interrupt logic here
    always_comb begin
        rd_data = 8'h00;
        if (cur.cmd[7:3] == BASIC_HI) begin
            case (cur.cmd[2:0])
                CMD_IN0[2:0], CMD_IN1[2:0]: rd_data = pins[cur.cmd[0]] ^ cur.pol[cur.cmd[0]];
                CMD_OUT0[2:0], CMD_OUT1[2:0]: rd_data = cur.outp[cur.cmd[0]];
                CMD_POL0[2:0], CMD_POL1[2:0]: rd_data = cur.pol[cur.cmd[0]];
                default: rd_data = cur.cfg[cur.cmd[0]];
            endcase
        // Bit 6 with low nibble for extended set
        end else if (cur.cmd[7:4] == EXT_HI) begin
            if (cur.cmd != CMD_STAT0 && cur.cmd != CMD_STAT1 && cur.cmd != CMD_GAP) begin
                rd_data = cur.ext[cur.cmd[3:0]];
            end
        end
    end

    always_comb begin
        next       = cur;
        next.scl_d = scl_sync[1];
        next.sda_d = sda_sync[1];
        if (start_cond) begin
            next.st     = ST_ADDR;
            next.cnt    = CNT_ZERO;
            next.sda_oe = 1'b0;
        end else if (stop_cond) begin
            next.st     = ST_IDLE;
            next.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (cur.st)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    next.shift = {cur.shift[6:0], sda_sync[1]};
                    next.cnt   = cur.cnt + 4'h1;
                end
                ST_RDATA: begin
                    next.cnt = cur.cnt + 4'h1;
                end
                ST_RACK: begin
                    // Master nack ends the read until a new start
                    next.st = sda_sync[1] ? ST_IDLE : ST_ACK_R;
                    if (!sda_sync[1]) begin
                        next.cmd = {cur.cmd[7:1], ~cur.cmd[0]};
                    end
                end
                default: begin
                    next.st = cur.st;
                end
            endcase
        end else if (scl_fall) begin
            case (cur.st)
                ST_ADDR: begin
                    if (cur.cnt == BITS_PER_BYTE) begin
                        if (cur.shift[7:1] == my_addr) begin
                            next.sda_oe = 1'b1;
                            // Direction bit picks read or write
                            next.st     = cur.shift[0] ? ST_ACK_R : ST_ACK_A;
                        end else begin
                            next.st = ST_IDLE;
                        end
                    end
                end
                ST_CMD: begin
                    if (cur.cnt == BITS_PER_BYTE) begin
                        next.cmd    = cur.shift;
                        next.sda_oe = 1'b1;
                        next.st     = ST_ACK_W;
                    end
                end
                ST_WDATA: begin
                    if (cur.cnt == BITS_PER_BYTE) begin
                        next.sda_oe = 1'b1;
                        next.st     = ST_ACK_W;
                        next.cmd    = {cur.cmd[7:1], ~cur.cmd[0]};
                        if (cur.cmd[7:3] == BASIC_HI) begin
                            // Input codes fall through with no effect
                            case (cur.cmd[2:1])
                                CMD_OUT0[2:1]: next.outp[cur.cmd[0]] = cur.shift;
                                CMD_POL0[2:1]: next.pol[cur.cmd[0]]  = cur.shift;
                                CMD_CFG0[2:1]: next.cfg[cur.cmd[0]]  = cur.shift;
                                default:       next.cfg              = cur.cfg;
                            endcase
                        end else if (cur.cmd[7:4] == EXT_HI && cur.cmd != CMD_STAT0
                                     && cur.cmd != CMD_STAT1 && cur.cmd != CMD_GAP) begin
                            // Extended registers are plain storage here
                            next.ext[cur.cmd[3:0]] = cur.shift;
                        end
                    end
                end
                ST_ACK_A: begin
                    next.sda_oe = 1'b0;
                    next.cnt    = CNT_ZERO;
                    next.st     = ST_CMD;
                end
                ST_ACK_W: begin
                    next.sda_oe = 1'b0;
                    next.cnt    = CNT_ZERO;
                    next.st     = ST_WDATA;
                end
                ST_ACK_R: begin
                    next.shift  = rd_data;
                    next.sda_oe = ~rd_data[7];
                    next.cnt    = CNT_ZERO;
                    next.st     = ST_RDATA;
                end
                ST_RDATA: begin
                    if (cur.cnt == BITS_PER_BYTE) begin
                        next.sda_oe = 1'b0;
                        next.st     = ST_RACK;
                    end else begin
                        next.sda_oe = ~cur.shift[3'(7 - cur.cnt)];
                    end
                end
                default: begin
                    next.st = cur.st;
                end
            endcase
        end
        // Direction from configuration, inputs at reset
        next.oe[0] = ~next.cfg[0];
        next.oe[1] = ~next.cfg[1];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur <= STATE_RESET;
        end else begin
            cur <= next;
        end
    end

    assign sda_out            = cur.sda_zero;
    assign sda_oe             = cur.sda_oe;
    assign low_bank_pins_out  = cur.outp[0];
    assign low_bank_pins_oe   = cur.oe[0];
    assign high_bank_pins_out = cur.outp[1];
    assign high_bank_pins_oe  = cur.oe[1];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence seq_addr_end;
        cur.st == ST_ADDR && scl_fall && !start_cond && !stop_cond
            && cur.cnt == BITS_PER_BYTE;
    endsequence
    sequence seq_cmd_end;
        cur.st == ST_CMD && scl_fall && !start_cond && !stop_cond
            && cur.cnt == BITS_PER_BYTE;
    endsequence

    chk_pins_reset_input: assert property ($rose(rst_n) |-> low_bank_pins_oe == 8'h00
        && high_bank_pins_oe == 8'h00) else $error("pins driven after reset");
    chk_addr_match_ack: assert property (seq_addr_end ##0 cur.shift[7:1] == my_addr
        |=> sda_oe ##0 cur.st inside {ST_ACK_A, ST_ACK_R}) else $error("own address not acked");
    chk_addr_miss_idle: assert property (seq_addr_end ##0 cur.shift[7:1] != my_addr
        |=> !sda_oe && cur.st == ST_IDLE) else $error("foreign address acked");
    chk_dir_bit_read: assert property (seq_addr_end ##0 cur.shift[7:1] == my_addr
        |=> (cur.st == ST_ACK_R) == $past(cur.shift[0])) else $error("direction bit misread");
    chk_cmd_capture: assert property (seq_cmd_end |=> cur.cmd == $past(cur.shift)
        ##1 sda_oe) else $error("command byte not stored");
    chk_basic_select: assert property (cur.cmd == CMD_IN1
        |-> rd_data == (pins[1] ^ cur.pol[1])) else $error("input bank 1 read wrong");
    chk_ext_select: assert property (cur.cmd == CMD_MASK0
        |-> rd_data == cur.ext[CMD_MASK0[3:0]]) else $error("mask register read wrong");
    chk_output_readback: assert property (cur.cmd == CMD_OUT0
        |-> rd_data == low_bank_pins_out) else $error("output read not stored value");
    chk_ptr_hold_idle: assert property (cur.st == ST_IDLE && !start_cond
        |=> $stable(cur.cmd)) else $error("pointer changed while idle");
    chk_oe_tracks_cfg: assert property ($changed(cur.cfg[1])
        |-> high_bank_pins_oe == ~cur.cfg[1]) else $error("bank 1 direction mismatch");
endmodule : gpio_exp_i2c

// ===== gpio_exp_i2c_tb.sv
// Self-checking testbench for the port expander I2C front end
`timescale 1ns/1ps
module gpio_exp_i2c_tb;
    import gpio_exp_pkg::*;
    logic            clk_sys = 1'b0;
    logic            reset_n;
    logic [2:0]      strap;
    logic [7:0]      lo_in, hi_in, lo_out, lo_oe, hi_out, hi_oe;
    logic            sda_out, sda_oe, scl, sda_low, rd_valid, sda_line;
    logic [7:0]      rd_data, d0, d1, p, c;
    logic [7:0]      exp_q[$];
    logic [7:0]      ext [8] = '{CMD_DRIVE0, CMD_LATCH0, CMD_PULLEN0, CMD_PULLSEL0,
                                 CMD_MASK0, CMD_STAT0, CMD_GAP, CMD_OUTCFG};
    int              n_errors, checked, cyc;

    always #20 clk_sys = ~clk_sys;
    // Pull-up on SDA, both parties open drain
    assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_low;

    gpio_exp_i2c uut (.clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap_0(strap[0]), .addr_strap_1(strap[1]), .addr_strap_2(strap[2]),
        .low_bank_pins_in(lo_in), .low_bank_pins_out(lo_out), .low_bank_pins_oe(lo_oe),
        .high_bank_pins_in(hi_in), .high_bank_pins_out(hi_out),
        .high_bank_pins_oe(hi_oe));
    i2c_master_model m (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl),
        .sda_low(sda_low), .rd_valid(rd_valid), .rd_data(rd_data));

    task automatic cmp_val(input string what, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_val

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    task automatic addr(input logic rw, input logic [2:0] s, input logic exp_ack);
        logic ack;
        m.start_c();
        m.wr_byte({ADDR_FIXED, s, rw}, ack);
        cmp_val("address ack", {7'h00, exp_ack}, {7'h00, ack});
    endtask : addr

    task automatic wr(input logic [7:0] cmd, input logic [7:0] a, input logic [7:0] b,
                      input int n);
        logic ack;
        addr(1'b0, strap, 1'b0);
        m.wr_byte(cmd, ack);
        cmp_val("command ack", 8'h00, {7'h00, ack});
        if (n > 0) begin
            m.wr_byte(a, ack);
            cmp_val("data ack", 8'h00, {7'h00, ack});
        end
        if (n > 1) begin
            m.wr_byte(b, ack);
            cmp_val("data ack", 8'h00, {7'h00, ack});
        end
        m.stop_c();
    endtask : wr

    task automatic rd(input logic [7:0] cmd, input logic setp, input int n);
        logic       ack;
        logic [7:0] d;
        if (setp) begin
            addr(1'b0, strap, 1'b0);
            m.wr_byte(cmd, ack);
            cmp_val("command ack", 8'h00, {7'h00, ack});
        end
        addr(1'b1, strap, 1'b0);
        for (int i = 0; i < n; i++) begin
            m.rd_byte(i == n - 1, d);
        end
        m.stop_c();
    endtask : rd

    // Oldest expectation meets each byte the master reads
    always @(posedge clk_sys) begin
        if (rd_valid) begin
            cmp_val("read byte", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rd_data);
        end
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            cmp_val("run length", 8'h00, 8'h01);
            wrap_up();
        end
    end

    initial begin
        reset_n = 1'b0;
        strap = 3'h0;
        lo_in = 8'h00;
        hi_in = 8'h00;
        n_errors = 0;
        checked = 0;
        cyc = 0;
        void'($urandom(12523));
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        cmp_val("low oe", 8'h00, lo_oe);
        cmp_val("high oe", 8'h00, hi_oe);
        $display("test reset done");
        // Every strap setting, then a foreign address
        for (int s = 0; s < 8; s++) begin
            strap <= 3'(s);
            repeat (3) @(posedge clk_sys);
            addr(1'b0, 3'(s), 1'b0);
            m.stop_c();
            addr(1'b0, 3'(s) ^ 3'h5, 1'b1);
            m.stop_c();
        end
        $display("test address done");
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        lo_in <= ~d0;
        hi_in <= ~d1;
        wr(CMD_OUT0, d0, d1, 2);
        wr(CMD_CFG0, 8'h00, 8'h0f, 2);
        cmp_val("low out", d0, lo_out);
        cmp_val("high out", d1, hi_out);
        cmp_val("low oe", 8'hff, lo_oe);
        cmp_val("high oe", 8'hf0, hi_oe);
        // No command byte: pointer still at configuration
        exp_q.push_back(8'h00);
        exp_q.push_back(8'h0f);
        rd(8'h00, 1'b0, 2);
        exp_q.push_back(d0);
        exp_q.push_back(d1);
        rd(CMD_OUT0, 1'b1, 2);
        $display("test output done");
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        p = 8'($urandom);
        lo_in <= d0;
        hi_in <= d1;
        wr(CMD_IN0, ~d0, ~d1, 2);
        wr(CMD_POL0, p, 8'h00, 2);
        exp_q.push_back(d0 ^ p);
        exp_q.push_back(d1);
        rd(CMD_IN0, 1'b1, 2);
        $display("test input done");
        // Extended codes: reset value, write, read back
        for (int i = 0; i < 8; i++) begin
            c = ext[i];
            d0 = 8'($urandom);
            exp_q.push_back(EXT_RESET[c[3:0]]);
            rd(c, 1'b1, 1);
            wr(c, d0, 8'h00, 1);
            exp_q.push_back((c == CMD_STAT0 || c == CMD_GAP) ? 8'h00 : d0);
            rd(c, 1'b1, 1);
        end
        $display("test extended done");
        wrap_up();
    end
endmodule : gpio_exp_i2c_tb

// ===== gpio_exp_pkg.sv
// Constants and types for the I2C port expander front end
package gpio_exp_pkg;
    localparam int           BANK_W        = 8;
    localparam int           STRAP_W       = 3;
    localparam logic [3:0]   ADDR_FIXED    = 4'h4;
    localparam logic [7:0]   CMD_RESET     = 8'h00;
    // Basic command codes
    localparam logic [7:0]   CMD_IN0       = 8'h00;
    localparam logic [7:0]   CMD_IN1       = 8'h01;
    localparam logic [7:0]   CMD_OUT0      = 8'h02;
    localparam logic [7:0]   CMD_OUT1      = 8'h03;
    localparam logic [7:0]   CMD_POL0      = 8'h04;
    localparam logic [7:0]   CMD_POL1      = 8'h05;
    localparam logic [7:0]   CMD_CFG0      = 8'h06;
    localparam logic [7:0]   CMD_CFG1      = 8'h07;
    // Extended command codes, low nibble indexes the extended array
    localparam logic [7:0]   CMD_DRIVE0    = 8'h40;
    localparam logic [7:0]   CMD_LATCH0    = 8'h44;
    localparam logic [7:0]   CMD_PULLEN0   = 8'h46;
    localparam logic [7:0]   CMD_PULLSEL0  = 8'h48;
    localparam logic [7:0]   CMD_MASK0     = 8'h4a;
    localparam logic [7:0]   CMD_STAT0     = 8'h4c;
    localparam logic [7:0]   CMD_STAT1     = 8'h4d;
    localparam logic [7:0]   CMD_GAP       = 8'h4e;
    localparam logic [7:0]   CMD_OUTCFG    = 8'h4f;
    localparam logic [4:0]   BASIC_HI      = 5'h00;
    localparam logic [3:0]   EXT_HI        = 4'h4;
    localparam int           EXT_N         = 16;
    // Reset values
    localparam logic [7:0]   OUT_RESET     = 8'hff;
    localparam logic [7:0]   POL_RESET     = 8'h00;
    localparam logic [7:0]   CFG_RESET     = 8'hff;
    localparam logic [EXT_N-1:0][7:0] EXT_RESET = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff};
    localparam logic [3:0]   BITS_PER_BYTE = 4'h8;
    localparam logic [3:0]   CNT_ZERO      = 4'h0;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACK_A, ST_CMD, ST_ACK_W, ST_WDATA, ST_ACK_R, ST_RDATA, ST_RACK
    } i2c_e;
endpackage : gpio_exp_pkg

// ===== i2c_master_model.sv
// Behavioural I2C bus master that drives the expander's serial pins
`timescale 1ns/1ps
module i2c_master_model (
    input  wire logic       clk_sys,
    input  wire logic       sda_line,
    output logic            scl,
    output logic            sda_low,
    output logic            rd_valid,
    output logic [7:0]      rd_data
);
    // Ten clocks per high phase, fifteen per low phase; the slave needs four at least
    localparam int HALF = 10;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end

    always @(posedge clk_sys) begin
        if (rd_valid) begin
            rd_valid <= 1'b0;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    // SDA only moves mid low phase, so no false start or stop
    task automatic bit_io(input logic b, output logic s);
        tick(HALF / 2);
        sda_low <= ~b;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        s = sda_line;
        scl <= 1'b0;
    endtask : bit_io

    task automatic start_c;
        tick(HALF / 2);
        sda_low <= 1'b0;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_low <= 1'b1;
        tick(HALF);
        scl <= 1'b0;
    endtask : start_c

    task automatic stop_c;
        tick(HALF / 2);
        sda_low <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_low <= 1'b0;
        tick(HALF);
    endtask : stop_c

    // MSB first, ninth clock samples the slave's acknowledge
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, ack);
    endtask : wr_byte

    // Released SDA during data bits; high ack on the last byte ends it
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        rd_data <= d;
        rd_valid <= 1'b1;
        bit_io(last, s);
    endtask : rd_byte
endmodule : i2c_master_model
